// ---- hw/pfta_flash_table.v ----
// program flash with table latch, holding registers and sequencer
// Function
// - Flash reads, writes and erases run during normal operation.
// - Every table read while the array is idle returns one byte chosen by a byte address.
// - A programming operation commits one whole 64-byte block.
// - An erase clears one aligned 1024-byte block.
// - A bulk erase requested by on-chip code is refused.
// - Instruction fetch is halted while a write or erase runs.
// - An internal timer ends each write and erase, then fetch resumes.
// - Any value is storable; invalid fetched words are the core's NOP.
// - Flash is 16 bits wide, RAM 8 bits, joined by one 8-bit latch.
// - A table read puts the addressed flash byte into the latch.
// - A table write fills holding registers only, never the array.
// - Table accesses take any byte address, no word alignment.
`include "pfta_regs.vh"
module pfta_flash_table #(
  parameter PROG_CYCLES = `PFTA_PROG_CYCLES
) (
  // clock and reset
  input  wire        CLOCK_IN,
  input  wire        RESET_IN,
  // table pointer
  input  wire        PTR_LOAD_IN,
  input  wire [13:0] PTR_DATA_IN,
  input  wire        PTR_INC_IN,
  output wire [13:0] PTR_OUT,
  // table latch
  input  wire        LATCH_LOAD_IN,
  input  wire [7:0]  LATCH_DATA_IN,
  output wire [7:0]  LATCH_OUT,
  // table operations
  input  wire        TABLE_READ_OP_IN,
  input  wire        TABLE_WRITE_OP_IN,
  // programming sequence
  input  wire        PROG_START_IN,
  input  wire [1:0]  PROG_OP_IN,
  output wire        BUSY_OUT,
  output reg         REFUSED_OUT,
  // instruction fetch
  input  wire [12:0] FETCH_ADDR_IN,
  output reg  [15:0] FETCH_DATA_OUT,
  output wire        FETCH_STALL_OUT
);
  localparam S_IDLE  = 2'h0;
  localparam S_WRITE = 2'h1;
  localparam S_ERASE = 2'h2;
  localparam WRITE_WORDS = `PFTA_BLOCK_BYTES / 2;
  localparam ERASE_WORDS = `PFTA_ERASE_BYTES / 2;

  reg [15:0] flash [0:`PFTA_WORDS-1];
  reg [7:0]  hold [0:`PFTA_BLOCK_BYTES-1];
  reg [13:0] table_ptr;
  reg [7:0]  table_latch;
  reg [1:0]  state;
  reg [31:0] timer;
  reg [13:0] op_base;
  // next values of the sequencer
  reg [1:0]  next_state;
  reg [31:0] next_timer;
  reg [13:0] next_op_base;
  reg        next_refused;
  wire       table_ok;
  wire       write_done;
  wire       erase_done;
  integer    i;

  // byte pick: odd address takes the high half
  function [7:0] pick_byte;
    input [15:0] word;
    input        hi;
    begin
      pick_byte = hi ? word[15:8] : word[7:0];
    end
  endfunction

  // clear the low bits to reach a block base
  function [13:0] align_down;
    input [13:0] addr;
    input integer shift;
    begin
      align_down = (addr >> shift) << shift;
    end
  endfunction

  // last count of the programming timer
  function last_tick;
    input [31:0] count;
    begin
      last_tick = (count == PROG_CYCLES - 1);
    end
  endfunction

  // word index inside the block being committed
  function [12:0] word_at;
    input [13:0] base;
    input [12:0] offset;
    begin
      word_at = base[13:1] + offset;
    end
  endfunction

  assign PTR_OUT   = table_ptr;
  assign LATCH_OUT = table_latch;
  assign BUSY_OUT  = (state != S_IDLE);
  assign FETCH_STALL_OUT = BUSY_OUT;
  // table ops are dropped while the array is busy, with no flag
  assign table_ok   = !BUSY_OUT;
  assign write_done = (state == S_WRITE) && last_tick(timer);
  assign erase_done = (state == S_ERASE) && last_tick(timer);

  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      table_ptr <= 14'h0000;
    end else if (PTR_LOAD_IN) begin
      table_ptr <= PTR_DATA_IN;
    end else if (PTR_INC_IN) begin
      table_ptr <= table_ptr + 14'h0001;
    end
  end

  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      table_latch <= 8'h00;
    end else if (TABLE_READ_OP_IN && table_ok) begin
      table_latch <= pick_byte(flash[table_ptr[13:1]], table_ptr[0]);
    end else if (LATCH_LOAD_IN) begin
      table_latch <= LATCH_DATA_IN;
    end
  end

  // table write lands in holding registers only
  // holding bytes survive a commit; refill before reuse
  always @(posedge CLOCK_IN) begin
    if (TABLE_WRITE_OP_IN && table_ok) begin
      hold[table_ptr[5:0]] <= table_latch;
    end
  end

  // any stored word is fetched as is; decode belongs to the core
  // fetch word freezes while the array is busy
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      FETCH_DATA_OUT <= 16'h0000;
    end else if (!BUSY_OUT) begin
      FETCH_DATA_OUT <= flash[FETCH_ADDR_IN];
    end
  end

  always @* begin
    next_state   = state;
    next_timer   = timer;
    next_op_base = op_base;
    next_refused = 1'h0;
    case (state)
      S_IDLE: begin
        if (PROG_START_IN) begin
          // timer restarts on every accepted start
          next_timer = 32'h00000000;
          if (PROG_OP_IN == `PFTA_OP_WRITE) begin
            next_op_base = align_down(table_ptr, `PFTA_HOLD_IDX_W);
            next_state   = S_WRITE;
          end else if (PROG_OP_IN == `PFTA_OP_ERASE) begin
            next_op_base = align_down(table_ptr, `PFTA_ERASE_SHIFT);
            next_state   = S_ERASE;
          end else if (PROG_OP_IN == `PFTA_OP_BULK) begin
            // bulk erase refused from user code
            next_refused = 1'h1;
          end
        end
      end
      S_WRITE, S_ERASE: begin
        if (last_tick(timer)) begin
          next_state = S_IDLE;
        end else begin
          next_timer = timer + 32'h00000001;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // sequencer registers; refusal is a one-cycle pulse
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state       <= S_IDLE;
      timer       <= 32'h00000000;
      op_base     <= 14'h0000;
      REFUSED_OUT <= 1'h0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      op_base     <= next_op_base;
      REFUSED_OUT <= next_refused;
    end
  end

  // array commit at end of timed operation; no reset on memory
  always @(posedge CLOCK_IN) begin
    if (write_done) begin
      for (i = 0; i < WRITE_WORDS; i = i + 1) begin
        flash[word_at(op_base, i[12:0])] <= {hold[2*i+1], hold[2*i]};
      end
    end else if (erase_done) begin
      for (i = 0; i < ERASE_WORDS; i = i + 1) begin
        flash[word_at(op_base, i[12:0])] <= `PFTA_ERASED_WORD;
      end
    end
  end
endmodule

// ---- hw/pfta_regs.vh ----
// constants for the program flash table access unit
`ifndef PFTA_REGS_VH
`define PFTA_REGS_VH
`define PFTA_ADDR_W        14
`define PFTA_WORDS         8192
`define PFTA_BLOCK_BYTES   64
`define PFTA_ERASE_BYTES   1024
`define PFTA_HOLD_IDX_W    6
`define PFTA_ERASE_SHIFT   10
`define PFTA_ERASED_WORD   16'hFFFF
`define PFTA_PROG_TIME_US  2000
`define PFTA_CLK_MHZ       20
`define PFTA_PROG_CYCLES   (`PFTA_PROG_TIME_US * `PFTA_CLK_MHZ)
`define PFTA_OP_WRITE      2'h1
`define PFTA_OP_ERASE      2'h2
`define PFTA_OP_BULK       2'h3
`endif

// ---- sim/pfta_chk.sv ----
// port assertions for the flash table access unit
module pfta_chk #(
  parameter PROG_CYCLES = 8
) (
  input wire logic        CLOCK_IN,
  input wire logic        RESET_IN,
  input wire logic        PTR_LOAD_IN,
  input wire logic [13:0] PTR_DATA_IN,
  input wire logic        PTR_INC_IN,
  input wire logic [13:0] PTR_OUT,
  input wire logic        PROG_START_IN,
  input wire logic [1:0]  PROG_OP_IN,
  input wire logic        BUSY_OUT,
  input wire logic        REFUSED_OUT,
  input wire logic [15:0] FETCH_DATA_OUT,
  input wire logic        FETCH_STALL_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  wire go = PROG_START_IN && !BUSY_OUT;
  int  n;
  always @(posedge CLOCK_IN or posedge RESET_IN)
    if (RESET_IN) n <= 0;
    else n <= BUSY_OUT ? n + 1 : 0;
  stall_eq_busy_a: assert property (FETCH_STALL_OUT == BUSY_OUT)
    else $error("stall differs from busy");
  bulk_refused_a: assert property (go && PROG_OP_IN == 2'h3 |=>
    REFUSED_OUT && !BUSY_OUT) else $error("bulk not refused");
  busy_len_a: assert property ($fell(BUSY_OUT) |-> n == PROG_CYCLES)
    else $error("busy length wrong");
  write_start_a: assert property (go && PROG_OP_IN == 2'h1 |=>
    BUSY_OUT) else $error("write did not start");
  erase_start_a: assert property (go && PROG_OP_IN == 2'h2 |=>
    BUSY_OUT) else $error("erase did not start");
  ptr_load_a: assert property (PTR_LOAD_IN |=>
    PTR_OUT == $past(PTR_DATA_IN)) else $error("pointer load wrong");
  ptr_inc_a: assert property (PTR_INC_IN && !PTR_LOAD_IN |=>
    PTR_OUT == $past(PTR_OUT) + 14'h0001) else $error("pointer step wrong");
  fetch_hold_a: assert property (BUSY_OUT && $past(BUSY_OUT) |->
    $stable(FETCH_DATA_OUT)) else $error("fetch moved while busy");
  cover property (go && PROG_OP_IN == 2'h1);
  cover property (go && PROG_OP_IN == 2'h2);
  cover property (REFUSED_OUT);
endmodule
bind pfta_flash_table pfta_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (
  .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .PTR_LOAD_IN(PTR_LOAD_IN),
  .PTR_DATA_IN(PTR_DATA_IN), .PTR_INC_IN(PTR_INC_IN), .PTR_OUT(PTR_OUT),
  .PROG_START_IN(PROG_START_IN), .PROG_OP_IN(PROG_OP_IN),
  .BUSY_OUT(BUSY_OUT), .REFUSED_OUT(REFUSED_OUT),
  .FETCH_DATA_OUT(FETCH_DATA_OUT), .FETCH_STALL_OUT(FETCH_STALL_OUT));

// ---- sim/pfta_core.sv ----
// core model issuing table and programming requests
module pfta_core (
  input  wire logic        clk,
  output logic      [13:0] a_out = 14'h0000,
  output logic      [7:0]  d_out = 8'h00,
  output logic      [7:0]  s_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle data lines toggle so a stale value is never mistaken for a load
  task automatic cyc(logic [13:0] a, logic [7:0] d, logic [7:0] s);
    @(negedge clk);
    a_out = s[7] ? a : ~a_out;
    d_out = s[5] ? d : ~d_out;
    s_out = s;
  endtask
endmodule

// ---- sim/test_program_flash_table_access.sv ----
// self-checking bench for the flash table access unit
module test_program_flash_table_access;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0;
  logic        rst = 1;
  wire  [13:0] a, ptr;
  wire  [7:0]  d, s, lat;
  wire  [15:0] fd;
  wire         bsy, stl, rf;
  int          n_errors = 0;
  int          check_count = 0;
  pfta_core core (.clk(clk), .a_out(a), .d_out(d), .s_out(s));
  pfta_flash_table #(.PROG_CYCLES(8)) dut (
    .CLOCK_IN(clk), .RESET_IN(rst), .PTR_LOAD_IN(s[7]),
    .PTR_DATA_IN(a), .PTR_INC_IN(s[6]), .PTR_OUT(ptr),
    .LATCH_LOAD_IN(s[5]), .LATCH_DATA_IN(d), .LATCH_OUT(lat),
    .TABLE_READ_OP_IN(s[4]), .TABLE_WRITE_OP_IN(s[3]),
    .PROG_START_IN(s[2]), .PROG_OP_IN(s[1:0]), .BUSY_OUT(bsy),
    .REFUSED_OUT(rf), .FETCH_ADDR_IN(13'h0020),
    .FETCH_DATA_OUT(fd), .FETCH_STALL_OUT(stl));
  initial forever #25 clk = ~clk;
  task automatic ck(string nm, logic [15:0] g, logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic prog(logic [1:0] op);
    core.cyc(0, 0, {6'h01, op});
    core.cyc(0, 0, 8'h00);
    ck("stall", stl, 1'h1);
    for (int i = 0; i < 20 && bsy === 1'h1; i++) @(negedge clk);
    ck("busy", bsy, 1'h0);
    @(negedge clk);
  endtask
  task automatic t_erase;
    core.cyc(14'h0041, 0, 8'h80);
    prog(2'h2);
    ck("erased", fd, 16'hFFFF);
  endtask
  task automatic t_write;
    core.cyc(14'h0040, 8'h5A, 8'hA0);
    core.cyc(0, 0, 8'h08);
    core.cyc(14'h0041, 8'hA5, 8'hA0);
    core.cyc(0, 0, 8'h18);
    core.cyc(0, 0, 8'h00);
    ck("held only", lat, 8'hFF);
    prog(2'h1);
    ck("word", fd, 16'hA55A);
    core.cyc(14'h0041, 0, 8'h80);
    core.cyc(0, 0, 8'h50);
    core.cyc(0, 0, 8'h00);
    ck("odd byte", lat, 8'hA5);
    ck("ptr", ptr, 14'h0042);
  endtask
  // op code zero starts nothing; busy array drops a table read
  task automatic t_ignore;
    core.cyc(0, 0, 8'h04);
    core.cyc(0, 0, 8'h00);
    ck("no op busy", bsy, 1'h0);
    ck("no op refused", rf, 1'h0);
    core.cyc(0, 0, 8'h05);
    core.cyc(0, 0, 8'h10);
    core.cyc(0, 0, 8'h00);
    ck("read dropped", lat, 8'hA5);
    for (int i = 0; i < 20 && bsy === 1'h1; i++) @(negedge clk);
    ck("done", bsy, 1'h0);
  endtask
  task automatic t_bulk;
    core.cyc(0, 0, 8'h07);
    core.cyc(0, 0, 8'h00);
    ck("refused", rf, 1'h1);
    ck("idle", bsy, 1'h0);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    t_erase;
    t_write;
    t_ignore;
    t_bulk;
    conclude;
  end
  initial begin
    #20000;
    n_errors++;
    conclude;
  end
endmodule
